// ===== modem_line_status_register.sv
`timescale 1ns/1ps
module modem_line_status_register #(
    parameter int CHANNEL = 0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Active-low modem lines from the pins
    input wire mlsr_pkg::mlsr_lines_t lines_n,
    // Channel configuration from neighbouring registers
    input wire logic [7:0] pin_function_select,
    input wire logic [7:0] modem_control_reg,
    input wire logic loopback_en,
    // Host read port
    input wire logic status_rd,
    output logic [7:0] status_data,
    // Pin-level bits that do not show true pin level
    output logic [7:0] pin_level_unreliable
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ----------------------------------------
    // Line sampling
    // ----------------------------------------
    localparam int SEL_BIT = (CHANNEL == 0) ? mlsr_pkg::FUNC_SEL_BIT_CH0
                                            : mlsr_pkg::FUNC_SEL_BIT_CH1;
    localparam logic [7:0] LEVEL_MASK = (CHANNEL == 0) ? mlsr_pkg::LEVEL_MASK_CH0
                                                       : mlsr_pkg::LEVEL_MASK_CH1;

    logic [3:0] line_lvl;
    logic [3:0] line_prev;
    logic func_en;
    logic loop_rts;
    logic loop_rts_prev;
    logic [3:0] src_now;
    logic [3:0] src_prev;
    logic [3:0] events;
    logic [3:0] flags;
    logic [7:0] live_status;

    mlsr_sync #(
        .WIDTH(mlsr_pkg::MODEM_LINES),
        .IDLE(mlsr_pkg::LINE_IDLE)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .async_in(lines_n),
        .level(line_lvl),
        .level_prev(line_prev)
    );

    assign func_en = pin_function_select[SEL_BIT];
    assign loop_rts = modem_control_reg[mlsr_pkg::CTRL_LOOP_RTS_BIT];

    // Previous loopback source, so loopback toggles also raise the change flag
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            loop_rts_prev <= 1'b0;
        else
            loop_rts_prev <= loop_rts;
    end

    // Clear-to-send source in active-low terms; loopback inverts the control bit
    always_comb
    begin
        src_now = line_lvl;
        src_prev = line_prev;
        if (loopback_en)
        begin
            src_now[0] = ~loop_rts;
            src_prev[0] = ~loop_rts_prev;
        end
    end

    // ----------------------------------------
    // Change detection
    // ----------------------------------------
    // Shared-pin lines only count while their function is assigned
    assign events[3] = func_en && (src_now[3] != src_prev[3]);
    assign events[2] = func_en && src_now[2] && !src_prev[2];
    assign events[1] = func_en && (src_now[1] != src_prev[1]);
    assign events[0] = src_now[0] != src_prev[0];

    // Set beats clear so a change during the read is kept
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_flag
            always_ff @(posedge ref_clk or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                    flags[i] <= 1'b0;
                else if (events[i])
                    flags[i] <= 1'b1;
                else if (status_rd)
                    flags[i] <= 1'b0;
            end
        end
    endgenerate

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    assign live_status = {
        func_en & ~src_now[3],
        func_en & ~src_now[2],
        func_en & ~src_now[1],
        ~src_now[0],
        flags
    };

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            status_data <= mlsr_pkg::STATUS_RESET;
        else if (status_rd)
            status_data <= live_status;
    end

    // Pin-level register must not trust these bits
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            pin_level_unreliable <= 8'h00;
        else
            pin_level_unreliable <= func_en ? LEVEL_MASK : 8'h00;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    property p_read_snapshot;
        status_rd |=> status_data == $past(live_status);
    endproperty
    a_read_snapshot: assert property (p_read_snapshot) else $error("read data mismatch");

    property p_carrier_level;
        live_status[7] == (func_en && !line_lvl[3]);
    endproperty
    a_carrier_level: assert property (p_carrier_level) else $error("carrier level wrong");

    property p_unassigned_zero;
        !func_en |-> live_status[7:5] == 3'h0;
    endproperty
    a_unassigned_zero: assert property (p_unassigned_zero) else $error("unassigned bits set");

    property p_clear_normal;
        !loopback_en |-> live_status[4] == !line_lvl[0];
    endproperty
    a_clear_normal: assert property (p_clear_normal) else $error("cts level wrong");

    property p_loop_follow;
        loopback_en |-> live_status[4] == loop_rts;
    endproperty
    a_loop_follow: assert property (p_loop_follow) else $error("loopback cts wrong");

    property p_carrier_chg;
        func_en && $changed(line_lvl[3]) |=> flags[3];
    endproperty
    a_carrier_chg: assert property (p_carrier_chg) else $error("carrier change lost");

    property p_bell_rise_only;
        $rose(flags[2]) |-> $past(src_now[2]) && !$past(src_prev[2]);
    endproperty
    a_bell_rise_only: assert property (p_bell_rise_only) else $error("bell flag not rise");

    property p_peer_chg;
        events[1] |=> flags[1] [*1] ##1 (flags[1] || $past(status_rd));
    endproperty
    a_peer_chg: assert property (p_peer_chg) else $error("peer change lost");

    property p_read_clears;
        status_rd && !events[0] |=> !flags[0];
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_set_wins;
        status_rd && events != 4'h0 |=> (flags & $past(events)) == $past(events);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on read");

    property p_flag_holds;
        flags[3] && !status_rd |=> flags[3];
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");

    c_read_with_flags: cover property (status_rd && flags != 4'h0);
    c_set_on_read: cover property (status_rd && events != 4'h0);
    c_loop_change: cover property (loopback_en && events[0]);
    c_bell_rise: cover property (events[2]);

endmodule // modem_line_status_register

// ===== mlsr_pkg.sv
package mlsr_pkg;

    // ----------------------------------------
    // Register layout
    // ----------------------------------------
    localparam int STATUS_WIDTH = 8;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int BIT_CARRIER_LVL = 7;
    localparam int BIT_BELL_LVL = 6;
    localparam int BIT_PEER_LVL = 5;
    localparam int BIT_CLEAR_LVL = 4;
    localparam int BIT_CARRIER_CHG = 3;
    localparam int BIT_BELL_RISE = 2;
    localparam int BIT_PEER_CHG = 1;
    localparam int BIT_CLEAR_CHG = 0;

    // Pin-function select bit per channel
    localparam int FUNC_SEL_BIT_CH0 = 1;
    localparam int FUNC_SEL_BIT_CH1 = 2;

    // Pin-level bits that lose meaning while a pin carries a modem function
    localparam logic [7:0] LEVEL_MASK_CH0 = 8'hD0;
    localparam logic [7:0] LEVEL_MASK_CH1 = 8'h0D;

    // Request-to-send control bit; steers the loopback clear-to-send source
    localparam int CTRL_LOOP_RTS_BIT = 1;

    // ----------------------------------------
    // Synchroniser
    // ----------------------------------------
    localparam int SYNC_STAGES = 2;
    localparam int MODEM_LINES = 4;
    // Inactive level of the active-low modem lines
    localparam logic [3:0] LINE_IDLE = 4'hF;

    // Raw active-low modem lines, index order matches change flags 3..0
    typedef struct packed {
        logic carrier;
        logic bell;
        logic peer;
        logic clear;
    } mlsr_lines_t;

endpackage

// ===== mlsr_sync.sv
`timescale 1ns/1ps
module mlsr_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Asynchronous lines in
    input wire logic [WIDTH-1:0] async_in,
    // Synchronised level and its previous value
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] level_prev
);

    logic [WIDTH-1:0] stage_one;

    // First stage is read by the second stage only
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_one <= IDLE;
            level <= IDLE;
        end
        else
        begin
            stage_one <= async_in;
            level <= stage_one;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            level_prev <= IDLE;
        else
            level_prev <= level;
    end

endmodule // mlsr_sync

// ===== mlsr_modem_model.sv
`timescale 1ns/1ps
module mlsr_modem_model (
    // Pin levels wanted by the bench
    input wire logic [3:0] want_n,
    // Active-low modem lines
    output mlsr_pkg::mlsr_lines_t lines_n
);
    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Driven lines, never released, so no floating level to model
    always_comb
    begin
        lines_n = want_n;
    end
endmodule // mlsr_modem_model

// ===== modem_line_status_register_tb_top.sv
`timescale 1ns/1ps
module modem_line_status_register_tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] want_n = 4'hF;
    logic [7:0] pin_function_select = 8'h02;
    logic [7:0] modem_control_reg = 8'h00;
    logic loopback_en = 1'b0;
    logic status_rd = 1'b0;
    mlsr_pkg::mlsr_lines_t lines_n;
    logic [7:0] status_data;
    logic [7:0] pin_level_unreliable;
    int fails = 0;
    int comparisons = 0;

    always #4 ref_clk = ~ref_clk;

    mlsr_modem_model modem_u (.want_n(want_n), .lines_n(lines_n));

    modem_line_status_register #(.CHANNEL(0)) dut_u (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .lines_n(lines_n),
        .pin_function_select(pin_function_select),
        .modem_control_reg(modem_control_reg),
        .loopback_en(loopback_en),
        .status_rd(status_rd),
        .status_data(status_data),
        .pin_level_unreliable(pin_level_unreliable)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // One-cycle read pulse; snapshot is settled by the next falling edge
    task automatic rd(input logic [7:0] exp, input string what);
        @(negedge ref_clk);
        status_rd = 1'b1;
        @(negedge ref_clk);
        status_rd = 1'b0;
        chk(what, exp, status_data);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_line(input int i);
        logic [7:0] lvl;
        logic [7:0] chg;
        lvl = 8'h10 << i;
        chg = 8'h01 << i;
        want_n[i] = 1'b0;
        cyc(5);
        // Bell flag only on the pin going back high
        rd(lvl | ((i == 2) ? 8'h00 : chg), "status after assert");
        rd(lvl, "status after clearing read");
        want_n[i] = 1'b1;
        cyc(5);
        rd(chg, "status after release");
        rd(8'h00, "status idle");
    endtask

    // Flag sets on the very edge that takes the read
    task automatic t_race();
        want_n[0] = 1'b0;
        cyc(2);
        status_rd = 1'b1;
        cyc(1);
        status_rd = 1'b0;
        cyc(1);
        rd(8'h11, "flag kept over read");
        want_n[0] = 1'b1;
        cyc(5);
        rd(8'h01, "flag after release");
    endtask

    // Channel 0 answers to select bit 1 only
    task automatic t_deselect();
        pin_function_select = 8'h04;
        cyc(3);
        chk("unreliable mask off", 8'h00, pin_level_unreliable);
        want_n = 4'h7;
        cyc(5);
        rd(8'h00, "carrier unassigned");
        want_n = 4'hF;
        cyc(5);
        rd(8'h00, "carrier unassigned release");
        pin_function_select = 8'h02;
        cyc(3);
        chk("unreliable mask back", 8'hD0, pin_level_unreliable);
    endtask

    task automatic t_loop();
        loopback_en = 1'b1;
        cyc(5);
        rd(8'h00, "loopback entry");
        modem_control_reg = 8'h02;
        cyc(5);
        rd(8'h11, "loopback follows control bit");
        want_n[0] = 1'b0;
        cyc(5);
        rd(8'h10, "loopback ignores pin");
        modem_control_reg = 8'h00;
        cyc(5);
        rd(8'h01, "loopback control bit drop");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        cyc(3);
        chk("status in reset", 8'h00, status_data);
        chk("unreliable in reset", 8'h00, pin_level_unreliable);
        cyc(7);
        rst_n = 1'b1;
        cyc(6);
        chk("unreliable mask on", 8'hD0, pin_level_unreliable);
        rd(8'h00, "status after reset");
        for (int i = 0; i < 4; i++)
            t_line(i);
        t_race();
        t_deselect();
        t_loop();
        test_done();
    end

    // Hang guard
    initial
    begin
        #800000;
        fails++;
        $display("mismatch watchdog expected done seen hang");
        test_done();
    end
endmodule // modem_line_status_register_tb_top
